// ### inc/wake_regs_params.svh
/*
  Offsets, reset values and field positions of the runtime register
  bank. Offsets are register indexes; the byte address on the bus is
  four times the index. Definitions only.
*/
`ifndef WAKE_REGS_PARAMS_SVH
`define WAKE_REGS_PARAMS_SVH

// ----------------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------------
`define IDX_WAKE_MASTER_STATUS 7'h00
`define IDX_WAKE_MASTER_ENABLE 7'h02
`define IDX_WAKE_SOURCE_STATUS_ONE 7'h04
`define IDX_WAKE_SOURCE_ENABLE_ONE 7'h0A
`define IDX_IRQ_STATUS 7'h0C
`define IDX_IRQ_MASK 7'h0D
`define IDX_DEVICE_DISABLE 7'h22
`define IDX_GPIO_PIN_FORTY_THREE 7'h3E
`define IDX_GPIO_CONFIG_THIRD 7'h4D
`define IDX_GENERAL_BANK_FOUR 7'h4E
`define IDX_GENERAL_BANK_FIVE 7'h4F
`define IDX_GENERAL_BANK_SIX 7'h50
`define IDX_WATCHDOG_TIMEOUT_SETTING 7'h52
`define IDX_WATCHDOG_COUNT_VALUE 7'h53
`define IDX_WATCHDOG_CONFIGURATION 7'h54
`define IDX_WATCHDOG_CONTROL 7'h55
`define IDX_FAN_OUTPUT_SETTING 7'h56
`define IDX_FAN_CONTROL 7'h58
`define IDX_FAN_TACHOMETER_COUNT 7'h59
`define IDX_FAN_PRELOAD_VALUE 7'h5B
`define IDX_INDICATOR_ONE_CONTROL 7'h5D
`define IDX_INDICATOR_TWO_CONTROL 7'h5E
`define IDX_KEYBOARD_SCAN_CODE 7'h5F
`define IDX_POWER_MGMT_CONTROL_ONE 7'h60
`define IDX_POWER_MGMT_CONTROL_TWO 7'h61
`define IDX_SYSMGMT_IRQ_STATUS_SEVEN 7'h64
`define IDX_SYSMGMT_IRQ_ENABLE_SEVEN 7'h66
`define IDX_WAKE_SOURCE_STATUS_SEVEN 7'h68
`define IDX_WAKE_SOURCE_ENABLE_SEVEN 7'h6C
`define IDX_RESERVED_TOP_FIRST 7'h6D

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define RST_ZERO 8'h00
`define RST_FAN_CONTROL 8'h10
`define RST_INDICATOR_TWO 8'h01
`define RST_GPIO_PIN_FORTY_THREE 8'h01
`define GPIO_PIN_FORTY_THREE_MODE_LO 2
`define GPIO_PIN_FORTY_THREE_MODE_LOCK 2'h1
`define GP3_FAN_BIT 3
`define DD_LOCK_BIT 1
`define WDT_KEEP_BIT 0
`define WDT_TRIGGER_BIT 2
`define WDT_EXPIRED_BIT 3
`define IRQ_SRC_EVENT 0
`define IRQ_FLAG_RISE 1
`define IRQ_DD_REFUSED 2

`endif

// ### inc/wake_regs_pkg.sv
/*
  Types of the runtime register bank: bank slots and module state.
  Assumes the constants of wake_regs_params.svh.
*/
package wake_regs_pkg;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic hit;
    logic hard_clr;
    logic [4:0] slot;
  } slot_t;

  typedef struct packed {
    byte_t bits;
  } sticky_t;

  typedef struct packed {
    logic ack;
    byte_t rdata;
    logic flag;
    logic enable;
    byte_t src_enable;
    byte_t irq_mask;
    logic [17:0][7:0] bank;
    logic [1:0] watchdog_control;
    logic wdt_trig;
    byte_t dev_dis;
    byte_t gp3;
    byte_t gpio_pin_forty_three;
    logic wake_n;
    logic par_irq;
    logic irq;
  } regs_t;

endpackage : wake_regs_pkg

// ### verilog/sticky_bits.sv
/*
  Eight sticky flags, set by hardware, cleared by writing one.
  Assumes set and clear are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_bits (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] set_i,
  input wire logic [7:0] clr_i,
  output logic [7:0] bits_o
);

  wake_regs_pkg::sticky_t state_ff;
  wake_regs_pkg::sticky_t nxt_state;

  // a set in the clearing cycle wins, so no event is lost
  always_comb
  begin
    nxt_state = state_ff;
    for (int i = 0; i < 8; i++)
    begin
      nxt_state.bits[i] = set_i[i] | (state_ff.bits[i] & ~clr_i[i]);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign bits_o = state_ff.bits;

endmodule : sticky_bits

`default_nettype wire

// ### verilog/runtime_regs_wake_events.sv
/*
  Runtime registers 0x4E..0x7F plus the wake-event master flag, master
  enable and first wake source status, on a classic Wishbone slave.
  Assumes resetn_i is the standby power-on reset and that main_por_i
  and hard_reset_i are synchronous levels from the platform reset logic.
*/
// Function
// - the master wake flag is set whenever the wake output would be driven, enabled or not.
// - writing one to the master wake flag clears it and releases the wake output; zero is ignored.
// - the master wake flag only resets on standby power-on reset.
// - the master wake enable blocks the wake output at zero and permits it at one.
// - the master wake enable only resets on standby power-on reset.
// - a wake source status bit sets on its source's event regardless of any enable.
// - status bits are line A, line B, ring one, keyboard, mouse, key, tachometer, ring two.
// - writing one clears a wake source status bit, and only standby reset clears the register.
// - reserved offsets, 0x6D..0x7F included, and reserved bits read zero.
// - device disable ignores writes while pin-43 mode 01 has the pin high or its bit 1 is set.
// - watchdog control bit 0 survives hard reset while bit 1 and the trigger bit clear; the expiry bit 3 follows its input.
// - watchdog control mixes read-only and write-only bits.
// - third GPIO config bit 3 clears on main power-on and hard reset.
// - pin-43 config field [3:2] clears on main power-on and hard reset.
// - the parallel interrupt reads one while the port is inactive, else follows acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "wake_regs_params.svh"

module runtime_regs_wake_events (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic main_por_i,
  input wire logic hard_reset_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic kbc_port_line_a_i,
  input wire logic kbc_port_line_b_i,
  input wire logic ring_indicator_one_n_i,
  input wire logic keyboard_wake_source_i,
  input wire logic mouse_wake_i,
  input wire logic specific_key_wake_i,
  input wire logic tachometer_wake_source_i,
  input wire logic ring_indicator_two_n_i,
  input wire logic gpio_pin_forty_three_i,
  input wire logic [7:0] tachometer_wake_source_count_i,
  input wire logic wdt_expired_i,
  input wire logic par_port_active_i,
  input wire logic acknowledge_in_n_i,
  output logic wake_event_out_n_o,
  output logic parallel_irq_line_o,
  output logic wdt_trigger_o,
  output logic [7:0] device_disable_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // slot map of the plain storage registers
  // ----------------------------------------------------------------------
  function automatic wake_regs_pkg::slot_t slot_of(input logic [6:0] idx);
    wake_regs_pkg::slot_t s;
    s = '0;
    s.hit = 1'b1;
    case (idx)
      `IDX_GENERAL_BANK_FOUR: s.slot = 5'h00;
      `IDX_GENERAL_BANK_FIVE: s.slot = 5'h01;
      `IDX_GENERAL_BANK_SIX: s.slot = 5'h02;
      `IDX_FAN_OUTPUT_SETTING: s.slot = 5'h03;
      `IDX_FAN_CONTROL: s.slot = 5'h04;
      `IDX_FAN_PRELOAD_VALUE: s.slot = 5'h05;
      `IDX_INDICATOR_ONE_CONTROL: s.slot = 5'h06;
      `IDX_INDICATOR_TWO_CONTROL: s.slot = 5'h07;
      `IDX_KEYBOARD_SCAN_CODE: s.slot = 5'h08;
      `IDX_POWER_MGMT_CONTROL_ONE: s.slot = 5'h09;
      `IDX_POWER_MGMT_CONTROL_TWO: s.slot = 5'h0A;
      `IDX_SYSMGMT_IRQ_STATUS_SEVEN: s.slot = 5'h0B;
      `IDX_SYSMGMT_IRQ_ENABLE_SEVEN: s.slot = 5'h0C;
      `IDX_WAKE_SOURCE_STATUS_SEVEN: s.slot = 5'h0D;
      `IDX_WAKE_SOURCE_ENABLE_SEVEN: s.slot = 5'h0E;
      `IDX_WATCHDOG_TIMEOUT_SETTING:
      begin
        s.slot = 5'h0F;
        s.hard_clr = 1'b1;
      end
      `IDX_WATCHDOG_COUNT_VALUE:
      begin
        s.slot = 5'h10;
        s.hard_clr = 1'b1;
      end
      `IDX_WATCHDOG_CONFIGURATION:
      begin
        s.slot = 5'h11;
        s.hard_clr = 1'b1;
      end
      default: s.hit = 1'b0;
    endcase
    return s;
  endfunction : slot_of

  function automatic logic [7:0] slot_reset(input int slot);
    case (slot)
      4: return `RST_FAN_CONTROL;
      7: return `RST_INDICATOR_TWO;
      default: return `RST_ZERO;
    endcase
  endfunction : slot_reset

  // ----------------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------------
  wake_regs_pkg::regs_t q_ff;
  wake_regs_pkg::regs_t nxt_q;
  wake_regs_pkg::slot_t sel_slot;
  logic [6:0] idx;
  logic [7:0] wdat;
  logic access;
  logic commit;
  logic [7:0] src_event;
  logic [7:0] src_sts;
  logic [7:0] src_clr;
  logic [7:0] irq_sts;
  logic [7:0] irq_clr;
  logic [7:0] irq_set;
  logic flag_set;
  logic flag_clr;
  logic dd_locked;
  logic dd_refused;
  logic any_reset;

  assign idx = adr_i[8:2];
  assign wdat = dat_i[7:0];
  assign sel_slot = slot_of(idx);
  assign access = cyc_i & stb_i & ~q_ff.ack;
  // writes land on the edge at which the master samples ack
  assign commit = cyc_i & stb_i & we_i & q_ff.ack & sel_i[0];
  assign any_reset = main_por_i | hard_reset_i;

  // order of bits: line A, line B, ring one, keyboard, mouse, key, tach, ring two
  assign src_event = {~ring_indicator_two_n_i, tachometer_wake_source_i,
                      specific_key_wake_i, mouse_wake_i, keyboard_wake_source_i,
                      ~ring_indicator_one_n_i, kbc_port_line_b_i, kbc_port_line_a_i};

  assign src_clr = (commit && idx == `IDX_WAKE_SOURCE_STATUS_ONE) ? wdat : 8'h00;
  assign irq_clr = (commit && idx == `IDX_IRQ_STATUS) ? wdat : 8'h00;

  // a new event on an enabled source is what would drive the wake output
  assign flag_set = |(src_event & q_ff.src_enable);
  assign flag_clr = commit && idx == `IDX_WAKE_MASTER_STATUS && wdat[0];

  assign dd_locked = (q_ff.gpio_pin_forty_three[`GPIO_PIN_FORTY_THREE_MODE_LO +: 2] == `GPIO_PIN_FORTY_THREE_MODE_LOCK
                      && gpio_pin_forty_three_i) || q_ff.dev_dis[`DD_LOCK_BIT];
  assign dd_refused = commit && idx == `IDX_DEVICE_DISABLE && dd_locked;

  assign irq_set = {5'h00, dd_refused, flag_set & ~q_ff.flag, |(src_event & ~src_sts)};

  // status bits set on the event whatever the enables say
  sticky_bits u_src_status (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .set_i(src_event),
    .clr_i(src_clr),
    .bits_o(src_sts)
  );

  sticky_bits u_irq_status (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .bits_o(irq_sts)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rd;
    rd = 8'h00;
    nxt_q = q_ff;
    nxt_q.ack = access;
    nxt_q.wdt_trig = 1'b0;

    // reserved offsets and bits fall through to zero
    if (sel_slot.hit)
      rd = q_ff.bank[sel_slot.slot];
    else
    begin
      case (idx)
        `IDX_WAKE_MASTER_STATUS: rd = {7'h00, q_ff.flag};
        `IDX_WAKE_MASTER_ENABLE: rd = {7'h00, q_ff.enable};
        `IDX_WAKE_SOURCE_STATUS_ONE: rd = src_sts;
        `IDX_WAKE_SOURCE_ENABLE_ONE: rd = q_ff.src_enable;
        `IDX_IRQ_STATUS: rd = irq_sts;
        `IDX_IRQ_MASK: rd = q_ff.irq_mask;
        `IDX_DEVICE_DISABLE: rd = q_ff.dev_dis;
        `IDX_GPIO_PIN_FORTY_THREE: rd = q_ff.gpio_pin_forty_three;
        `IDX_GPIO_CONFIG_THIRD: rd = q_ff.gp3;
        `IDX_FAN_TACHOMETER_COUNT: rd = tachometer_wake_source_count_i;
        // trigger bit is write-only, expiry bit read-only
        `IDX_WATCHDOG_CONTROL: rd = {4'h0, wdt_expired_i, 1'b0, q_ff.watchdog_control};
        default: rd = 8'h00;
      endcase
    end
    nxt_q.rdata = access && !we_i ? rd : 8'h00;

    if (commit)
    begin
      if (sel_slot.hit)
        nxt_q.bank[sel_slot.slot] = wdat;
      case (idx)
        `IDX_WAKE_MASTER_ENABLE: nxt_q.enable = wdat[0];
        `IDX_WAKE_SOURCE_ENABLE_ONE: nxt_q.src_enable = wdat;
        `IDX_IRQ_MASK: nxt_q.irq_mask = wdat;
        `IDX_GPIO_PIN_FORTY_THREE: nxt_q.gpio_pin_forty_three = wdat;
        `IDX_GPIO_CONFIG_THIRD: nxt_q.gp3 = wdat;
        `IDX_WATCHDOG_CONTROL:
        begin
          nxt_q.watchdog_control = wdat[1:0];
          nxt_q.wdt_trig = wdat[`WDT_TRIGGER_BIT];
        end
        `IDX_DEVICE_DISABLE:
        begin
          if (!dd_locked)
            nxt_q.dev_dis = wdat;
        end
        default: nxt_q.irq_mask = nxt_q.irq_mask;
      endcase
    end

    // main power-on and hard reset; the wake registers are left alone
    if (any_reset)
    begin
      for (int s = 15; s < 18; s++)
      begin
        nxt_q.bank[s] = slot_reset(s);
      end
      nxt_q.watchdog_control[1] = 1'b0;
      if (main_por_i)
        nxt_q.watchdog_control[`WDT_KEEP_BIT] = 1'b0;
      nxt_q.wdt_trig = 1'b0;
      nxt_q.gp3[`GP3_FAN_BIT] = 1'b0;
      nxt_q.gpio_pin_forty_three[`GPIO_PIN_FORTY_THREE_MODE_LO +: 2] = 2'h0;
    end

    // set beats clear in the same cycle
    nxt_q.flag = flag_set | (q_ff.flag & ~flag_clr);
    nxt_q.wake_n = ~(nxt_q.flag & nxt_q.enable);
    nxt_q.par_irq = par_port_active_i ? acknowledge_in_n_i : 1'b1;
    nxt_q.irq = |((irq_set | (irq_sts & ~irq_clr)) & nxt_q.irq_mask);
  end

  // only the standby reset is asynchronous
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q_ff <= '0;
      for (int s = 0; s < 18; s++)
      begin
        q_ff.bank[s] <= slot_reset(s);
      end
      q_ff.gpio_pin_forty_three <= `RST_GPIO_PIN_FORTY_THREE;
      q_ff.wake_n <= 1'b1;
      q_ff.par_irq <= 1'b1;
    end
    else
      q_ff <= nxt_q;
  end

  assign dat_o = {24'h000000, q_ff.rdata};
  assign ack_o = q_ff.ack;
  assign wake_event_out_n_o = q_ff.wake_n;
  assign parallel_irq_line_o = q_ff.par_irq;
  assign wdt_trigger_o = q_ff.wdt_trig;
  assign device_disable_o = q_ff.dev_dis;
  assign irq_o = q_ff.irq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_FLAG_SET: assert property (flag_set |=> q_ff.flag ##0 src_sts != 8'h00)
    else $error("master flag not set on enabled wake event");
  // flag and wake output are registered together, so the release shows in the same cycle
  AST_FLAG_CLR: assert property (flag_clr && !flag_set |=>
    !q_ff.flag && wake_event_out_n_o)
    else $error("master flag write-one clear failed");
  AST_FLAG_KEEP: assert property (any_reset && !flag_clr |=> q_ff.flag || !$past(q_ff.flag))
    else $error("master flag lost on main or hard reset");
  // a write that sets the enable in this cycle may legally drive the output next cycle
  AST_ENABLE_GATES: assert property (!q_ff.enable && !(commit &&
    idx == `IDX_WAKE_MASTER_ENABLE && wdat[0]) |=> wake_event_out_n_o)
    else $error("wake output active while disabled");
  AST_ENABLE_KEEP: assert property (any_reset && !commit |=> $stable(q_ff.enable))
    else $error("master enable changed on main or hard reset");
  AST_SRC_SET: assert property (src_event != 8'h00 |=>
    (src_sts & $past(src_event)) == $past(src_event))
    else $error("wake source status bit not set");
  AST_SRC_W1C: assert property (src_clr != 8'h00 && src_event == 8'h00 |=>
    (src_sts & $past(src_clr)) == 8'h00)
    else $error("wake source status not cleared by one");
  AST_RSVD_ZERO: assert property (ack_o && !we_i && idx >= `IDX_RESERVED_TOP_FIRST |->
    dat_o == 32'h00000000)
    else $error("reserved offset read nonzero");
  AST_DD_LOCK: assert property (dd_refused && !any_reset |=> $stable(device_disable_o))
    else $error("locked device disable accepted a write");
  AST_WDT_HARD: assert property (hard_reset_i && !main_por_i |=>
    q_ff.watchdog_control[0] == $past(q_ff.watchdog_control[0]) && !q_ff.watchdog_control[1])
    else $error("watchdog control wrong after hard reset");
  AST_WDT_WO: assert property (ack_o && !we_i && idx == `IDX_WATCHDOG_CONTROL |->
    !dat_o[`WDT_TRIGGER_BIT])
    else $error("write-only watchdog bit read back");
  AST_GP_CLR: assert property (any_reset |=>
    !q_ff.gp3[`GP3_FAN_BIT] && q_ff.gpio_pin_forty_three[3:2] == 2'h0)
    else $error("gpio config bits not cleared by reset");
  AST_PAR_IRQ: assert property (!par_port_active_i |=> parallel_irq_line_o ##0 1'b1)
    else $error("parallel interrupt not high while inactive");
  AST_PAR_FOLLOW: assert property (par_port_active_i |=>
    parallel_irq_line_o == $past(acknowledge_in_n_i))
    else $error("parallel interrupt does not follow acknowledge");
  AST_WAKE_OUT: assert property (##1 wake_event_out_n_o == !(q_ff.flag && q_ff.enable))
    else $error("wake output disagrees with flag and enable");

endmodule : runtime_regs_wake_events

`default_nettype wire

// ### verification/tb_top.sv
/*
  Self-checking bench for runtime_regs_wake_events: bus, wake, resets, irq.
  Assumes a one-cycle registered ack and byte address = 4 * index.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, rstn, mpor, hrst, cyc, stb, we, ack, wake_n, pirq, trig, irq;
  logic pin43, wdx, pact, ackn;
  logic [8:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [7:0] src, tach, ddis;
  int error_cnt = 0;
  int n_checks = 0;
  int trig_cnt = 0;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ring indicators are active low, so src stays active high here
  runtime_regs_wake_events dut (
    .clk_i(clk), .resetn_i(rstn), .main_por_i(mpor), .hard_reset_i(hrst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .kbc_port_line_a_i(src[0]), .kbc_port_line_b_i(src[1]),
    .ring_indicator_one_n_i(~src[2]), .keyboard_wake_source_i(src[3]),
    .mouse_wake_i(src[4]), .specific_key_wake_i(src[5]),
    .tachometer_wake_source_i(src[6]), .ring_indicator_two_n_i(~src[7]),
    .gpio_pin_forty_three_i(pin43), .tachometer_wake_source_count_i(tach),
    .wdt_expired_i(wdx), .par_port_active_i(pact), .acknowledge_in_n_i(ackn),
    .wake_event_out_n_o(wake_n), .parallel_irq_line_o(pirq),
    .wdt_trigger_o(trig), .device_disable_o(ddis), .irq_o(irq)
  );

  always @(posedge clk)
    if (trig === 1'b1)
      trig_cnt++;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // entered just after an edge; returns one idle cycle after the ack edge
  task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {i, 2'b00};
    wdat <= {24'h000000, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n == 20)
    begin
      error_cnt++;
      report_and_stop;
    end
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask : wr

  task automatic rc(input logic [6:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rc

  task automatic ev(input logic [7:0] s);
    src <= s;
    tick(1);
    src <= 8'h00;
    tick(2);
  endtask : ev

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] e;
    rc(7'h00, 8'h00);
    rc(7'h02, 8'h00);
    rc(7'h04, 8'h00);
    chk(32'(wake_n), 32'h1);
    for (int i = 'h4E; i < 'h80; i++)
    begin
      if (i == 'h55)
        continue;
      e = (i == 'h58) ? 8'h10 : (i == 'h5E) ? 8'h01 : (i == 'h59) ? 8'h3C : 8'h00;
      rc(7'(i), e);
      wr(7'(i), 8'hA5 ^ 8'(i));
      case (i)
        'h4E, 'h4F, 'h50, 'h52, 'h53, 'h54, 'h56, 'h58, 'h5B, 'h5D, 'h5E, 'h5F,
        'h60, 'h61, 'h64, 'h66, 'h68, 'h6C: e = 8'hA5 ^ 8'(i);
        'h59: e = 8'h3C;
        default: e = 8'h00;
      endcase
      rc(7'(i), e);
    end
    $display("test regs done");
  endtask : t_regs

  task automatic t_wake;
    wr(7'h0A, 8'h10);
    ev(8'h10);
    rc(7'h04, 8'h10);
    rc(7'h00, 8'h01);
    chk(32'(wake_n), 32'h1);
    wr(7'h02, 8'hFF);
    rc(7'h02, 8'h01);
    chk(32'(wake_n), 32'h0);
    wr(7'h00, 8'h00);
    rc(7'h00, 8'h01);
    wr(7'h00, 8'h01);
    tick(2);
    chk(32'(wake_n), 32'h1);
    rc(7'h00, 8'h00);
    wr(7'h04, 8'h00);
    rc(7'h04, 8'h10);
    wr(7'h04, 8'h10);
    rc(7'h04, 8'h00);
    $display("test wake done");
  endtask : t_wake

  task automatic t_src;
    wr(7'h0A, 8'h00);
    for (int b = 0; b < 8; b++)
    begin
      ev(8'h01 << b);
      rc(7'h04, 8'h01 << b);
      rc(7'h00, 8'h00);
      wr(7'h04, 8'h01 << b);
    end
    $display("test sources done");
  endtask : t_src

  task automatic t_rst;
    wr(7'h0A, 8'h01);
    ev(8'h01);
    wr(7'h52, 8'h5A);
    wr(7'h55, 8'h03);
    wr(7'h4D, 8'h0F);
    wr(7'h3E, 8'h0D);
    wdx <= 1'b1;
    hrst <= 1'b1;
    tick(1);
    hrst <= 1'b0;
    tick(1);
    rc(7'h52, 8'h00);
    rc(7'h55, 8'h09);
    rc(7'h4D, 8'h07);
    rc(7'h3E, 8'h01);
    rc(7'h00, 8'h01);
    rc(7'h02, 8'h01);
    rc(7'h04, 8'h01);
    mpor <= 1'b1;
    tick(1);
    mpor <= 1'b0;
    tick(1);
    rc(7'h55, 8'h08);
    rc(7'h00, 8'h01);
    rc(7'h02, 8'h01);
    chk(32'(wake_n), 32'h0);
    wdx <= 1'b0;
    wr(7'h55, 8'h04);
    tick(2);
    chk(32'(trig_cnt), 32'h1);
    rc(7'h55, 8'h00);
    wr(7'h00, 8'h01);
    wr(7'h04, 8'hFF);
    $display("test resets done");
  endtask : t_rst

  task automatic t_irq;
    wr(7'h0C, 8'hFF);
    wr(7'h0D, 8'h00);
    ev(8'h08);
    rc(7'h0C, 8'h01);
    chk(32'(irq), 32'h0);
    wr(7'h0D, 8'h01);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(7'h0C, 8'h01);
    tick(2);
    chk(32'(irq), 32'h0);
    rc(7'h0C, 8'h00);
    $display("test irq done");
  endtask : t_irq

  task automatic t_par;
    tick(2);
    chk(32'(pirq), 32'h1);
    pact <= 1'b1;
    tick(3);
    chk(32'(pirq), 32'h0);
    ackn <= 1'b1;
    tick(3);
    chk(32'(pirq), 32'h1);
    $display("test parallel done");
  endtask : t_par

  // locks for good, so this runs last
  task automatic t_dd;
    wr(7'h3E, 8'h05);
    pin43 <= 1'b1;
    wr(7'h22, 8'h20);
    rc(7'h22, 8'h00);
    rc(7'h0C, 8'h04);
    pin43 <= 1'b0;
    wr(7'h22, 8'h02);
    wr(7'h22, 8'h40);
    rc(7'h22, 8'h02);
    chk(32'(ddis), 32'h2);
    $display("test disable done");
  endtask : t_dd

  initial
  begin
    rstn = 1'b0;
    {mpor, hrst, cyc, stb, we, pin43, wdx, pact, ackn} = 9'h000;
    adr = 9'h000;
    sel = 4'h0;
    wdat = 32'h00000000;
    src = 8'h00;
    tach = 8'h3C;
    tick(16);
    rstn <= 1'b1;
    tick(1);
    t_regs;
    t_wake;
    t_src;
    t_rst;
    t_irq;
    t_par;
    t_dd;
    report_and_stop;
  end
endmodule : tb_top

`default_nettype wire
